// [hdl/ccg_pkg.sv]
// Purpose: Shared constants and types for the CPU slowdown and module gating block.
// Assumes: 100 MHz pclk, APB register access, 16-bit registers in the low word lanes.
// Notes:   Offsets are byte addresses on the APB bus.
`default_nettype none
package ccg_pkg;
   localparam int          APB_AW        = 12;
   localparam logic [11:0] CLOCK_DIVIDER_REGISTER_OFS    = 12'h000;
   localparam logic [11:0] PMG_OFS       = 12'h004;
   localparam logic [11:0] STAT_OFS      = 12'h008;

   // clock_divider_register fields.
   localparam int          ROI_BIT       = 15;
   localparam int          RATIO_MSB     = 14;
   localparam int          RATIO_LSB     = 12;
   localparam int          SLOW_BIT      = 11;
   localparam logic [15:0] CLOCK_DIVIDER_REGISTER_RST    = 16'h0000;
   localparam logic [15:0] CLOCK_DIVIDER_REGISTER_WMASK  = 16'hf800;

   // pwm_module_gating fields: generator 1, 2 and 4 gates.
   localparam int          NUM_GEN       = 3;
   localparam logic [NUM_GEN-1:0][3:0] GEN_POS = {4'hb, 4'h9, 4'h8};
   localparam logic [15:0] PMG_RST       = 16'h0000;
   localparam logic [15:0] PMG_WMASK     = 16'h0b00;

   // Status register fields.
   localparam int          ST_SLOW_BIT   = 0;
   localparam int          ST_RATIO_LSB  = 1;
   localparam int          ST_ON_LSB     = 8;

   localparam int          RATIO_W       = 3;
   localparam int          DIV_W         = 7;

   // One instruction cycle is two oscillator periods.
   localparam int          PCLK_MHZ      = 100;
   localparam int          INSTR_CYC_NS  = 20;
   localparam int          GATE_DLY_CYC  = (INSTR_CYC_NS * PCLK_MHZ + 999) / 1000;

   typedef enum logic [0:0] {CCG_FULL, CCG_SLOW} ccg_mode_t;
endpackage
`default_nettype wire

// [hdl/ccg_doze_div.sv]
// Purpose: Produces the CPU clock enable at pclk divided by 2**ratio.
// Assumes: ratio is stable except when restart is pulsed.
// Notes:   The enable is cut from pclk, so both domains share every edge.
`default_nettype none
module ccg_doze_div
   import ccg_pkg::*;
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               slow,
   input  wire logic [RATIO_W-1:0] ratio,
   input  wire logic               restart,
   output logic                    cpu_tick
);
   logic [DIV_W-1:0] cnt_r;
   logic [DIV_W-1:0] cnt_nxt;
   logic [DIV_W-1:0] limit;

   always_comb
   begin
      limit = DIV_W'((8'h01 << ratio) - 8'h01);   // see R15
      if (!slow || restart)
      begin
         cnt_nxt = '0;
      end
      else if (cnt_r >= limit)
      begin
         cnt_nxt = '0;
      end
      else
      begin
         cnt_nxt = cnt_r + 7'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_r <= '0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
      end
   end

   // A tick always lands on a pclk edge where peripherals also tick.
   assign cpu_tick = !slow || (cnt_r == 7'h00);   // see R02
endmodule
`default_nettype wire

// [hdl/ccg_gate_bank.sv]
// Purpose: Per-module clock gate with a fixed delay and register access blocking.
// Assumes: gate_req comes straight from the software gating bits.
// Notes:   Read data from a gated module must not be trusted by software.
`default_nettype none
module ccg_gate_bank
   import ccg_pkg::*;
#(
   parameter int N     = NUM_GEN,
   parameter int DELAY = GATE_DLY_CYC
)
(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [N-1:0] gate_req,
   input  wire logic [N-1:0] present,
   input  wire logic [N-1:0] mod_wr,
   output logic      [N-1:0] mod_on,
   output logic      [N-1:0] mod_wr_pass,
   output logic      [N-1:0] mod_rd_valid
);
   generate
      if (N < 1 || DELAY < 1)
      begin : g_bad
         $error("ccg_gate_bank needs N and DELAY of at least one");
      end
   endgenerate

   logic [N-1:0][DELAY-1:0] pipe_r;
   logic [N-1:0][DELAY-1:0] pipe_nxt;

   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : g_ch
         if (DELAY == 1)
         begin : g_one
            assign pipe_nxt[g] = gate_req[g];
         end
         else
         begin : g_many
            assign pipe_nxt[g] = {pipe_r[g][DELAY-2:0], gate_req[g]};   // see R11
         end
         // A module is on only if present and its gate is clear.
         assign mod_on[g]       = present[g] && !pipe_r[g][DELAY-1];   // see R09
         assign mod_wr_pass[g]  = mod_wr[g] && mod_on[g];              // see R08
         assign mod_rd_valid[g] = mod_on[g];                           // see R08
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pipe_r <= '0;   // see R10
      end
      else
      begin
         pipe_r <= pipe_nxt;
      end
   end
endmodule
`default_nettype wire

// [hdl/ccg_top.sv]
// Purpose: CPU slowdown mode and PWM generator clock gating behind an APB slave.
// Assumes: pclk is the system clock; irq_event is a one-cycle pulse per interrupt.
// Notes:   The CPU clock is delivered as an enable, never as a gated clock.
// Notes on behaviour
// R01: In slowdown mode the system clock and peripheral clocks keep full speed; only the CPU slows.
// R02: The slow CPU clock and the full-speed peripheral clock stay aligned to the same edges.
// R03: Setting the slowdown enable bit (bit 11) enters slowdown mode and clearing it leaves.
// R04: Bits 14 to 12 pick one of eight CPU ratios from 1:1 to 1:128, reset value 1:1.
// R05: With the return-on-interrupt bit (bit 15) set, an interrupt restores full CPU speed.
// R06: With the return-on-interrupt bit clear, interrupts leave mode and ratio alone.
// R07: Setting a module gate bit stops every clock to that module.
// R08: A gated module ignores register writes and its reads are not valid.
// R09: A module is enabled only if its gate bit is clear and it is present in the variant.
// R10: All gate bits reset to zero so present modules start enabled.
// R11: A gate bit change takes effect one instruction cycle after the write.
// R12: Gating bit 11 disables PWM generator 4 when one, enables it when zero.
// R13: Gating bit 9 gates PWM generator 2 and bit 8 gates PWM generator 1, one disables.
// R14: Gating bits 15 to 12, 10 and 7 to 0 read zero and ignore writes.
// R15: Ratio code 000 is 1:1 and each higher code doubles it up to 1:128 at 111.
`default_nettype none
module ccg_top
   import ccg_pkg::*;
#(
   parameter logic [NUM_GEN-1:0] GEN_PRESENT = 3'h7
)
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [APB_AW-1:0]  paddr,
   input  wire logic [31:0]        pwdata,
   input  wire logic [3:0]         pstrb,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               irq_event,
   output logic                    cpu_clk_en,
   output logic                    periph_clk_en,
   input  wire logic [NUM_GEN-1:0] pwm_reg_wr,
   output logic      [NUM_GEN-1:0] pwm_reg_wr_pass,
   output logic      [NUM_GEN-1:0] pwm_reg_rd_valid,
   output logic      [NUM_GEN-1:0] pwm_gen_clk_en
);
   // APB register state.
   logic [15:0]        clock_divider_register_r;
   logic [15:0]        clock_divider_register_nxt;
   logic [15:0]        pmg_r;
   logic [15:0]        pmg_nxt;
   logic [31:0]        rdata_r;
   logic [31:0]        rdata_nxt;
   logic               err_r;
   logic               err_nxt;

   // Mode state.
   ccg_mode_t          mode_r;
   ccg_mode_t          mode_nxt;
   logic [RATIO_W-1:0] ratio_r;
   logic [RATIO_W-1:0] ratio_nxt;
   logic               restart;

   logic               setup;
   logic               wr_acc;
   logic               hit_clock_divider_register;
   logic               hit_pmg;
   logic               hit_stat;
   logic               hit_any;
   logic [15:0]        lane_mask;
   logic [15:0]        stat_word;
   logic [NUM_GEN-1:0] gate_bits;
   logic [NUM_GEN-1:0] mod_on;

   // Address decode; only aligned words hit.
   always_comb
   begin
      hit_clock_divider_register = (paddr == CLOCK_DIVIDER_REGISTER_OFS);
      hit_pmg    = (paddr == PMG_OFS);
      hit_stat   = (paddr == STAT_OFS);
      hit_any    = hit_clock_divider_register || hit_pmg || hit_stat;
      setup      = psel && !penable;
      wr_acc     = psel && penable && pwrite;
      lane_mask  = {{8{pstrb[1]}}, {8{pstrb[0]}}};
   end

   // Status shows what the block is doing now, not what software asked for.
   always_comb
   begin
      stat_word                                     = 16'h0000;
      stat_word[ST_SLOW_BIT]                        = (mode_r == CCG_SLOW);
      stat_word[ST_RATIO_LSB +: RATIO_W]            = ratio_r;
      stat_word[ST_ON_LSB +: NUM_GEN]               = mod_on;
   end

   // Register writes, plus the hardware clear of the slowdown bit on interrupt.
   always_comb
   begin
      clock_divider_register_nxt = clock_divider_register_r;
      pmg_nxt    = pmg_r;
      if (wr_acc && hit_clock_divider_register)
      begin
         clock_divider_register_nxt = (clock_divider_register_r & ~(lane_mask & CLOCK_DIVIDER_REGISTER_WMASK))
                    | (pwdata[15:0] & lane_mask & CLOCK_DIVIDER_REGISTER_WMASK);   // see R03 see R04
      end
      if (wr_acc && hit_pmg)
      begin
         pmg_nxt = (pmg_r & ~(lane_mask & PMG_WMASK))
                 | (pwdata[15:0] & lane_mask & PMG_WMASK);         // see R14
      end
      // The interrupt wins over a same-cycle write so no wake-up is lost.
      if (irq_event && clock_divider_register_r[ROI_BIT])
      begin
         clock_divider_register_nxt[SLOW_BIT] = 1'b0;                              // see R05
      end
   end

   // Read data is prepared in the setup cycle so it comes from a flop.
   always_comb
   begin
      rdata_nxt = rdata_r;
      err_nxt   = err_r;
      if (setup)
      begin
         err_nxt   = !hit_any;
         rdata_nxt = 32'h0000_0000;
         if (hit_clock_divider_register)
         begin
            rdata_nxt[15:0] = clock_divider_register_r & CLOCK_DIVIDER_REGISTER_WMASK;
         end
         else if (hit_pmg)
         begin
            rdata_nxt[15:0] = pmg_r & PMG_WMASK;                   // see R14
         end
         else if (hit_stat)
         begin
            rdata_nxt[15:0] = stat_word;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         clock_divider_register_r <= CLOCK_DIVIDER_REGISTER_RST;                                   // see R04
         pmg_r    <= PMG_RST;                                      // see R10
         rdata_r  <= 32'h0000_0000;
         err_r    <= 1'b0;
      end
      else
      begin
         clock_divider_register_r <= clock_divider_register_nxt;
         pmg_r    <= pmg_nxt;
         rdata_r  <= rdata_nxt;
         err_r    <= err_nxt;
      end
   end

   assign pready  = 1'b1;
   assign prdata  = rdata_r;
   assign pslverr = psel && penable && err_r;

   // Mode follows the enable bit; a ratio change restarts the divider count.
   always_comb
   begin
      mode_nxt  = mode_r;
      ratio_nxt = clock_divider_register_r[RATIO_MSB:RATIO_LSB];                   // see R04
      unique case (mode_r)
         CCG_FULL:
         begin
            if (clock_divider_register_r[SLOW_BIT])
            begin
               mode_nxt = CCG_SLOW;                                // see R03
            end
         end
         CCG_SLOW:
         begin
            // Without the return bit an interrupt changes nothing here.
            if (!clock_divider_register_r[SLOW_BIT])
            begin
               mode_nxt = CCG_FULL;                                // see R03 see R06
            end
         end
      endcase
      restart = (mode_r != mode_nxt) || (ratio_r != ratio_nxt);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_r  <= CCG_FULL;
         ratio_r <= '0;
      end
      else
      begin
         mode_r  <= mode_nxt;
         ratio_r <= ratio_nxt;
      end
   end

   ccg_doze_div u_div
   (
      .pclk     (pclk),
      .presetn  (presetn),
      .slow     (mode_r == CCG_SLOW),
      .ratio    (ratio_r),
      .restart  (restart),
      .cpu_tick (cpu_clk_en)                                       // see R02
   );

   // Peripherals never see the slowdown; the system clock is untouched.
   assign periph_clk_en = 1'b1;                                    // see R01

   genvar g;
   generate
      for (g = 0; g < NUM_GEN; g++)
      begin : g_gate
         assign gate_bits[g] = pmg_r[GEN_POS[g]];                  // see R12 see R13
      end
   endgenerate

   ccg_gate_bank #(
      .N     (NUM_GEN),
      .DELAY (GATE_DLY_CYC)
   ) u_gate
   (
      .pclk         (pclk),
      .presetn      (presetn),
      .gate_req     (gate_bits),
      .present      (GEN_PRESENT),
      .mod_wr       (pwm_reg_wr),
      .mod_on       (mod_on),
      .mod_wr_pass  (pwm_reg_wr_pass),                             // see R08
      .mod_rd_valid (pwm_reg_rd_valid)
   );

   // A gated generator loses every clock, including the full-speed one.
   assign pwm_gen_clk_en = mod_on & {NUM_GEN{periph_clk_en}};      // see R07
endmodule
`default_nettype wire

// [bench/ccg_asserts.sv]
// Purpose: Port-level checks of CPU slowdown timing and PWM generator gating.
// Assumes: Register writes carry all byte strobes.
// Notes:   Divider writes are spaced at least four cycles apart by the bench.
`default_nettype none
module ccg_asserts
   import ccg_pkg::*;
#(
   parameter logic [NUM_GEN-1:0] GEN_PRESENT = 3'h7
)
(
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [APB_AW-1:0]  paddr,
   input wire logic [31:0]        pwdata,
   input wire logic               irq_event,
   input wire logic               cpu_clk_en,
   input wire logic               periph_clk_en,
   input wire logic [NUM_GEN-1:0] pwm_reg_wr,
   input wire logic [NUM_GEN-1:0] pwm_reg_wr_pass,
   input wire logic [NUM_GEN-1:0] pwm_reg_rd_valid,
   input wire logic [NUM_GEN-1:0] pwm_gen_clk_en
);
   timeunit 1ns;
   timeprecision 1ps;
   logic               wr_cd;
   logic               wr_pmg;
   logic [NUM_GEN-1:0] gen_exp;
   logic [4:0]         cd_r;
   logic [4:0]         cd_nxt;
   logic               slow_new;
   assign wr_cd   = psel && penable && pwrite && (paddr == CLOCK_DIVIDER_REGISTER_OFS);
   assign wr_pmg  = psel && penable && pwrite && (paddr == PMG_OFS);
   assign gen_exp = ~{pwdata[11], pwdata[9], pwdata[8]} & GEN_PRESENT;
   // The tick phase is only pinned down when a write enters slow mode or changes the ratio;
   // rewriting the same setting leaves the divider count running.
   assign slow_new = !cd_r[0] || (pwdata[14:12] != cd_r[3:1]);
   // Shadow of divider bits 15 to 11; an armed interrupt clears the slow bit, as in hardware.
   always_comb
   begin
      cd_nxt = cd_r;
      if (wr_cd)
      begin
         cd_nxt = pwdata[15:11];
      end
      if (irq_event && cd_r[4])
      begin
         cd_nxt[0] = 1'b0;
      end
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cd_r <= 5'h00;
      end
      else
      begin
         cd_r <= cd_nxt;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_one_tick;
      cpu_clk_en ##1 !cpu_clk_en;
   endsequence
   sequence s_full_run;
      cpu_clk_en [*3];
   endsequence
   a_periph_full: assert property (periph_clk_en == 1'b1)
      else $error("peripheral clock enable dropped");
   a_slow_tick: assert property (wr_cd && pwdata[SLOW_BIT] && pwdata[14:12] != 3'h0
      && slow_new |-> ##2 s_one_tick) else $error("slow mode tick misplaced");
   a_full_run: assert property (wr_cd && !pwdata[SLOW_BIT] |-> ##2 s_full_run)
      else $error("cpu enable not constant at full speed");
   a_irq_full: assert property (irq_event && cd_r[4] |-> ##2 s_full_run)
      else $error("interrupt did not restore full speed");
   a_gate_delay: assert property (wr_pmg |-> ##3 pwm_gen_clk_en == $past(gen_exp, 3))
      else $error("gate state wrong one instruction cycle after write");
   a_gate_hold: assert property ($changed(pwm_gen_clk_en) |-> $past(wr_pmg, 3))
      else $error("gate changed without a write");
   a_wr_block: assert property (pwm_reg_wr_pass == (pwm_reg_wr & pwm_gen_clk_en))
      else $error("write passed to gated module");
   a_rd_valid: assert property (pwm_reg_rd_valid == pwm_gen_clk_en)
      else $error("read valid disagrees with gate");
   a_absent_off: assert property ((pwm_gen_clk_en & ~GEN_PRESENT) == '0)
      else $error("absent generator clocked");
endmodule
bind ccg_top ccg_asserts #(.GEN_PRESENT(GEN_PRESENT)) u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .irq_event(irq_event), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
   .pwm_reg_wr(pwm_reg_wr), .pwm_reg_wr_pass(pwm_reg_wr_pass),
   .pwm_reg_rd_valid(pwm_reg_rd_valid), .pwm_gen_clk_en(pwm_gen_clk_en));
`default_nettype wire

// [bench/ccg_core_model.sv]
// Purpose: Stand-in for the core and PWM generators: interrupts, writes, CPU tick count.
// Assumes: Bench commands change right after a rising edge.
// Notes:   A held interrupt request still leaves as one-cycle pulses.
`default_nettype none
module ccg_core_model
   import ccg_pkg::*;
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               cpu_clk_en,
   input  wire logic               irq_req,
   input  wire logic [NUM_GEN-1:0] wr_req,
   output logic                    irq_event,
   output logic      [NUM_GEN-1:0] pwm_reg_wr,
   output logic      [15:0]        ticks
);
   timeunit 1ns;
   timeprecision 1ps;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_event  <= 1'b0;
         pwm_reg_wr <= '0;
         ticks      <= '0;
      end
      else
      begin
         irq_event  <= irq_req && !irq_event;
         pwm_reg_wr <= wr_req;
         ticks      <= ticks + 16'(cpu_clk_en);
      end
   end
endmodule
`default_nettype wire

// [bench/cpu_clock_slowdown_and_module_gating_test.sv]
// Purpose: Directed checks of CPU slowdown, interrupt return and PWM gating.
// Assumes: Generator 2 is left out of this variant so absent modules are exercised.
// Notes:   Slow-mode tick windows span two divider periods, so the divider phase never matters.
`default_nettype none
module cpu_clock_slowdown_and_module_gating_test
   import ccg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [NUM_GEN-1:0] PRES = 3'h5;
   logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic               irq_req, irq_event, cpu_clk_en, periph_clk_en, rerr;
   logic [APB_AW-1:0]  paddr;
   logic [31:0]        pwdata, prdata, rdat;
   logic [NUM_GEN-1:0] wr_req, pwm_reg_wr, pwm_reg_wr_pass, pwm_reg_rd_valid, pwm_gen_clk_en;
   logic [15:0]        ticks;
   int                 miscompares = 0;
   int                 n_compared = 0;
   ccg_top #(.GEN_PRESENT(PRES)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_event(irq_event),
      .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .pwm_reg_wr(pwm_reg_wr),
      .pwm_reg_wr_pass(pwm_reg_wr_pass), .pwm_reg_rd_valid(pwm_reg_rd_valid),
      .pwm_gen_clk_en(pwm_gen_clk_en));
   ccg_core_model core (.pclk(pclk), .presetn(presetn), .cpu_clk_en(cpu_clk_en),
      .irq_req(irq_req), .wr_req(wr_req), .irq_event(irq_event), .pwm_reg_wr(pwm_reg_wr),
      .ticks(ticks));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic win(input int n, input int exp);
      logic [15:0] t0;
      @(posedge pclk);
      #1;
      t0 = ticks;
      repeat (n) @(posedge pclk);
      #1;
      chk(32'(ticks - t0), exp);
   endtask
   task automatic pulse;
      @(posedge pclk);
      irq_req <= 1'b1;
      @(posedge pclk);
      irq_req <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic t_reset;
      apb(1'b0, CLOCK_DIVIDER_REGISTER_OFS, '0);
      chk(rdat, 32'(CLOCK_DIVIDER_REGISTER_RST));
      apb(1'b0, PMG_OFS, '0);
      chk(rdat, 32'h0);
      chk(32'(pwm_gen_clk_en), 32'(PRES));
      win(8, 8);
      $display("test reset done");
   endtask
   task automatic t_ratio;
      for (int r = 0; r < 8; r++)
      begin
         apb(1'b1, CLOCK_DIVIDER_REGISTER_OFS, 32'h0800 | (r << 12));
         win(2 << r, 2);
         apb(1'b0, STAT_OFS, '0);
         chk(rdat, 32'h0501 | (r << 1));
      end
      apb(1'b1, CLOCK_DIVIDER_REGISTER_OFS, '0);
      win(16, 16);
      $display("test ratio done");
   endtask
   task automatic t_irq;
      apb(1'b1, CLOCK_DIVIDER_REGISTER_OFS, 32'h3800);
      pulse();
      apb(1'b0, CLOCK_DIVIDER_REGISTER_OFS, '0);
      chk(rdat, 32'h3800);
      win(16, 2);
      apb(1'b1, CLOCK_DIVIDER_REGISTER_OFS, 32'hb800);
      pulse();
      apb(1'b0, CLOCK_DIVIDER_REGISTER_OFS, '0);
      chk(rdat, 32'hb000);
      win(16, 16);
      $display("test interrupt done");
   endtask
   task automatic t_gate;
      @(posedge pclk);
      wr_req <= 3'h7;
      apb(1'b1, PMG_OFS, 32'hffff);
      @(posedge pclk);
      #1;
      chk(32'(pwm_gen_clk_en), 32'(PRES));
      @(posedge pclk);
      #1;
      chk(32'(pwm_gen_clk_en | pwm_reg_wr_pass | pwm_reg_rd_valid), 32'h0);
      apb(1'b0, PMG_OFS, '0);
      chk(rdat, 32'h0b00);
      apb(1'b1, PMG_OFS, 32'h0100);
      repeat (2) @(posedge pclk);
      #1;
      chk(32'(pwm_reg_wr_pass), 32'(PRES & 3'h6));
      apb(1'b0, 12'h00c, '0);
      chk({rdat[31:1], rerr}, 32'h1);
      $display("test gating done");
   endtask
   task automatic final_report;
      $display("compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial
   begin
      {presetn, psel, penable, pwrite, irq_req, paddr, pwdata, wr_req} = '0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_ratio();
      t_irq();
      t_gate();
      final_report();
   end
   // Whole run needs under two thousand cycles; this leaves ample margin.
   initial
   begin
      #200us;
      miscompares++;
      final_report();
   end
endmodule
`default_nettype wire
